// >>> src/hsc_pkg.sv
// ---------------------------------------------------------------------------
// constants and carrier types for one high speed counter channel
// ---------------------------------------------------------------------------
// assumes a 32-bit classic wishbone master and a single 100 MHz clock
package hsc_pkg;

  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RING_LO  = 8'h04;
  localparam logic [7:0] OFS_RING_HI  = 8'h08;
  localparam logic [7:0] OFS_CMP_BASE = 8'h0C; // mode, value1, value2 per compare
  localparam logic [7:0] CMP_STRIDE   = 8'h0C;
  localparam logic [7:0] OFS_COUNT    = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;

  // -------------------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------------------
  localparam int CTRL_COUNT_EN = 0;
  localparam int CTRL_RING_EN  = 1;
  localparam int CTRL_CMP_EN   = 2; // two bits
  localparam int CTRL_PIN_EN   = 4; // two bits
  localparam int CTRL_CB_RESET = 6; // write one pulse
  localparam int CTRL_EQ_CLR   = 7; // two bits, write one pulse

  // -------------------------------------------------------------------------
  // values
  // -------------------------------------------------------------------------
  localparam logic [31:0] COUNT_MAX  = 32'h7FFF_FFFF;
  localparam logic [31:0] COUNT_MIN  = 32'h8000_0000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0]  ERR_NONE   = 8'h00;
  localparam logic [7:0]  ERR_CMP    = 8'h17; // 23
  localparam logic [7:0]  ERR_RING   = 8'h1B; // 27
  localparam logic [3:0]  CMP_LT     = 4'h0;
  localparam logic [3:0]  CMP_LE     = 4'h1;
  localparam logic [3:0]  CMP_EQ     = 4'h2;
  localparam logic [3:0]  CMP_GE     = 4'h3;
  localparam logic [3:0]  CMP_GT     = 4'h4;
  localparam logic [3:0]  CMP_IN     = 4'h5;
  localparam logic [3:0]  CMP_OUT    = 4'h6;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LINEAR     = 2'b00,
    ST_RING_IN    = 2'b01,
    ST_RING_BELOW = 2'b10,
    ST_RING_ABOVE = 2'b11
  } cnt_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic               count_en;
    logic               ring_en;
    logic [1:0]         cmp_en;
    logic [1:0]         pin_en;
    logic signed [31:0] ring_lo;
    logic signed [31:0] ring_hi;
    logic [1:0][3:0]    cmp_mode;
    logic [1:0][31:0]   cmp_v1;
    logic [1:0][31:0]   cmp_v2;
    logic signed [31:0] count;
    logic               carry;
    logic               borrow;
    logic [1:0]         eq;
    logic [1:0]         cmp_out;
    logic [7:0]         err;
    cnt_mode_t          mode;
    logic [1:0]         sync_up;
    logic [1:0]         sync_dn;
    logic               up_d;
    logic               dn_d;
    logic               ack;
    logic [31:0]        rdata;
  } hsc_state_t;

endpackage : hsc_pkg

// >>> src/hsc_compare.sv
// ---------------------------------------------------------------------------
// one compare condition evaluator
// ---------------------------------------------------------------------------
// assumes count and values are signed 32-bit words from the same clock
`timescale 1ns/10ps
module hsc_compare (
  // operands
  input  wire logic [31:0] count_i,
  input  wire logic [3:0]  mode_i,
  input  wire logic [31:0] v1_i,
  input  wire logic [31:0] v2_i,
  // result
  output logic             hit_o,
  output logic             bad_o
);

  logic signed [31:0] c;
  logic signed [31:0] a;
  logic signed [31:0] b;

  assign c = count_i;
  assign a = v1_i;
  assign b = v2_i;

  // condition select, illegal codes give no hit
  always_comb begin
    hit_o = 1'b0;
    bad_o = 1'b0;
    case (mode_i)
      hsc_pkg::CMP_LT:  hit_o = c < a;
      hsc_pkg::CMP_LE:  hit_o = c <= a;
      hsc_pkg::CMP_EQ:  hit_o = c == a;
      hsc_pkg::CMP_GE:  hit_o = c >= a;
      hsc_pkg::CMP_GT:  hit_o = c > a;
      hsc_pkg::CMP_IN:  hit_o = (c >= a) && (c <= b);
      hsc_pkg::CMP_OUT: hit_o = (c <= a) || (c >= b);
      default:          bad_o = 1'b1;
    endcase
  end

endmodule : hsc_compare

// >>> src/hsc_channel.sv
// ---------------------------------------------------------------------------
// high speed counter channel: linear/ring count, carry, borrow, two compares
// ---------------------------------------------------------------------------
// assumes count step pins come from an encoder decoder outside this clock,
// and a classic wishbone master with 32-bit data
`timescale 1ns/10ps
module hsc_channel (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // register bus
  input  wire hsc_pkg::wb_req_t wb_req_i,
  output hsc_pkg::wb_rsp_t      wb_rsp_o,
  // count step pins
  input  wire logic             count_up_i,
  input  wire logic             count_dn_i,
  // compare pins and flags
  output logic [1:0]            cmp_out_o,
  output logic                  carry_o,
  output logic                  borrow_o
);

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  // byte offsets, the two low address bits are ignored:
  //   0x00 control: b0 count enable, b1 ring enable, b3:2 compare enable,
  //        b5:4 pin assign; b6 carry/borrow reset and b8:7 equality
  //        clear are write-one pulses that read back as zero
  //   0x04 ring lower limit, 0x08 ring upper limit, both signed
  //   0x0c, 0x10, 0x14 compare 0 condition code, value 1, value 2
  //   0x18, 0x1c, 0x20 compare 1 condition code, value 1, value 2
  //   0x24 count, a write presets it
  //   0x28 status: b0 carry, b1 borrow, b3:2 compare met, b5:4 count
  //        state, b15:8 error code; any write clears the error code
  // unmapped offsets answer with zero data and ignore writes.
  // a request is answered one cycle after it is taken and ack lasts one
  // cycle; the master must drop its strobe for a cycle before the next.
  //
  // step pin timing, in clock edges after the pin rises:
  //   edge 2  second synchroniser stage high
  //   edge 3  count, carry and borrow change
  //   edge 4  compare flags and compare pins follow the new count
  // a pin must stay high and low at least one cycle each, two to be safe;
  // a pin already high when reset ends is not seen as a step, since reset clears count enable.
  // ring counting only behaves as a ring once the count lies inside the
  // limits, so the program should preset the count there first.

  // -------------------------------------------------------------------------
  // state and helpers
  // -------------------------------------------------------------------------
  hsc_pkg::hsc_state_t q;
  hsc_pkg::hsc_state_t s;

  logic [1:0] hit;
  logic [1:0] bad;

  // merge write data into an old word under byte selects
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        r[8*k +: 8] = new_w[8*k +: 8];
      end
    end
    return r;
  endfunction : merge

  // -------------------------------------------------------------------------
  // compare evaluators
  // -------------------------------------------------------------------------
  // both evaluators see the registered count, so flags lag it one cycle
  // two independent compares
  for (genvar g = 0; g < 2; g++) begin : g_cmp
    hsc_compare u_cmp (
      .count_i (q.count),
      .mode_i  (q.cmp_mode[g]),
      .v1_i    (q.cmp_v1[g]),
      .v2_i    (q.cmp_v2[g]),
      .hit_o   (hit[g]),
      .bad_o   (bad[g])
    );
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic               take;
    logic               wr;
    logic [7:0]         addr;
    logic [31:0]        ctrl_w;
    logic [31:0]        tmp;
    logic [31:0]        rd;
    logic               step_up;
    logic               step_dn;
    logic signed [31:0] inc;
    logic signed [31:0] dec;
    logic               ring_rise;
    logic [1:0]         eq_clr;
    logic [7:0]         ofs;
    s         = q;
    // a request is taken only while ack is low, so a held strobe is retaken every second cycle
    take      = wb_req_i.cyc && wb_req_i.stb && !q.ack;
    wr        = take && wb_req_i.we;
    addr      = {wb_req_i.adr[7:2], 2'b00};
    // old control bits under the byte selects; the pulse bits start at zero
    ctrl_w    = merge({25'h000_0000, q.pin_en, q.cmp_en, q.ring_en, q.count_en, 1'b0} >> 1,
                      wb_req_i.dat, wb_req_i.sel);
    tmp       = 32'h0000_0000;
    rd        = 32'h0000_0000;
    inc       = q.count + 32'sh0000_0001;
    dec       = q.count - 32'sh0000_0001;
    ring_rise = 1'b0;
    eq_clr    = 2'b00;
    ofs       = 8'h00;
    // only the second synchroniser stage feeds logic
    step_up   = q.sync_up[1] && !q.up_d && q.count_en;
    step_dn   = q.sync_dn[1] && !q.dn_d && q.count_en;

    // ------------------------------
    // bus answer in the cycle after the request is seen
    // ------------------------------
    s.ack = take;

    // ------------------------------
    // pin synchronisers and rising edge detect
    // ------------------------------
    s.sync_up = {q.sync_up[0], count_up_i};
    s.sync_dn = {q.sync_dn[0], count_dn_i};
    s.up_d    = q.sync_up[1];
    s.dn_d    = q.sync_dn[1];

    // ------------------------------
    // flag clears from control and status writes
    // ------------------------------
    // a ring wrap in the same cycle sets the flag again below, so the set wins
    // carry and borrow cleared by the reset control only
    if (wr && addr == hsc_pkg::OFS_CTRL && ctrl_w[hsc_pkg::CTRL_CB_RESET]) begin
      s.carry  = 1'b0;
      s.borrow = 1'b0;
    end
    if (wr && addr == hsc_pkg::OFS_CTRL) begin
      eq_clr = ctrl_w[hsc_pkg::CTRL_EQ_CLR +: 2];
    end

    // error code cleared by any status write, new errors win
    if (wr && addr == hsc_pkg::OFS_STATUS) begin
      s.err = hsc_pkg::ERR_NONE;
    end

    // ------------------------------
    // count step, simultaneous up and down cancel
    // ------------------------------
    if (step_up && !step_dn) begin
      if (q.mode == hsc_pkg::ST_RING_IN) begin
        // the wrap is taken on the step that would show the upper limit
        // wrap to lower limit, upper limit not shown
        if (inc >= q.ring_hi) begin
          s.count = q.ring_lo;
          // carry on wrap, counting goes on
          s.carry = 1'b1;
        end else begin
          s.count = inc;
        end
      end else if (!q.carry && q.count != hsc_pkg::COUNT_MAX) begin
        // the flag blocks as well as the value, so a cleared carry at the
        // maximum still leaves further increments without effect
        // increments blocked after carry
        s.count = inc;
        if (inc == hsc_pkg::COUNT_MAX) begin
          s.carry = 1'b1;
        end
      end
    end else if (step_dn && !step_up) begin
      if (q.mode == hsc_pkg::ST_RING_IN) begin
        // wrap to upper limit with borrow
        // borrow in ring mode keeps counting
        if (q.count <= q.ring_lo) begin
          s.count  = q.ring_hi;
          s.borrow = 1'b1;
        end else begin
          s.count = dec;
        end
      end else if (!q.borrow && q.count != hsc_pkg::COUNT_MIN) begin
        s.count = dec;
        if (dec == hsc_pkg::COUNT_MIN) begin
          s.borrow = 1'b1;
        end
      end
    end

    // ------------------------------
    // leave the below-range state once the count is inside the limits
    // ------------------------------
    // below-range ring becomes true ring once inside
    if (q.mode == hsc_pkg::ST_RING_BELOW && s.count >= q.ring_lo && s.count <= q.ring_hi) begin
      s.mode = hsc_pkg::ST_RING_IN;
    end

    // ------------------------------
    // register writes
    // ------------------------------
    if (wr) begin
      unique case (addr)
        hsc_pkg::OFS_CTRL: begin
          s.count_en = ctrl_w[hsc_pkg::CTRL_COUNT_EN];
          s.ring_en  = ctrl_w[hsc_pkg::CTRL_RING_EN];
          s.cmp_en   = ctrl_w[hsc_pkg::CTRL_CMP_EN +: 2];
          s.pin_en   = ctrl_w[hsc_pkg::CTRL_PIN_EN +: 2];
          ring_rise  = ctrl_w[hsc_pkg::CTRL_RING_EN] && !q.ring_en;
          // dropping ring enable returns to linear counting at once
          if (!ctrl_w[hsc_pkg::CTRL_RING_EN]) begin
            s.mode = hsc_pkg::ST_LINEAR;
          end
        end
        hsc_pkg::OFS_RING_LO: s.ring_lo = merge(q.ring_lo, wb_req_i.dat, wb_req_i.sel);
        hsc_pkg::OFS_RING_HI: s.ring_hi = merge(q.ring_hi, wb_req_i.dat, wb_req_i.sel);
        // preset lets the program move the count into range
        hsc_pkg::OFS_COUNT:   s.count = merge(q.count, wb_req_i.dat, wb_req_i.sel);
        default: begin
          for (int i = 0; i < 2; i++) begin
            ofs = 8'(hsc_pkg::OFS_CMP_BASE + 8'(i) * hsc_pkg::CMP_STRIDE);
            if (addr == ofs) begin
              tmp           = merge({28'h000_0000, q.cmp_mode[i]}, wb_req_i.dat, wb_req_i.sel);
              s.cmp_mode[i] = tmp[3:0];
            end
            if (addr == 8'(ofs + 8'h04)) begin
              s.cmp_v1[i] = merge(q.cmp_v1[i], wb_req_i.dat, wb_req_i.sel);
            end
            if (addr == 8'(ofs + 8'h08)) begin
              s.cmp_v2[i] = merge(q.cmp_v2[i], wb_req_i.dat, wb_req_i.sel);
            end
          end
        end
      endcase
    end

    // ------------------------------
    // ring selected: classify the present count
    // ------------------------------
    // the count before this write is used, so a preset must come in an
    // earlier transfer than the ring enable
    if (ring_rise) begin
      if (q.count < q.ring_lo) begin
        s.mode = hsc_pkg::ST_RING_BELOW;
        s.err  = hsc_pkg::ERR_RING;
      end else if (q.count > q.ring_hi) begin
        // above range, linear with error, and unlike below range it never turns to ring counting
        s.mode = hsc_pkg::ST_RING_ABOVE;
        s.err  = hsc_pkg::ERR_RING;
      end else begin
        s.mode = hsc_pkg::ST_RING_IN;
      end
    end

    // ------------------------------
    // compare flags from the registered count
    // ------------------------------
    for (int i = 0; i < 2; i++) begin
      // raised again every cycle the code stands, even while disabled
      // illegal condition code reports its error
      if (bad[i]) begin
        s.err = hsc_pkg::ERR_CMP;
      end
      if (!q.cmp_en[i] || bad[i]) begin
        s.eq[i] = 1'b0;
      end else if (q.cmp_mode[i] == hsc_pkg::CMP_EQ) begin
        // a clear and a new hit in one cycle keep the flag on
        // equality holds until cleared, new hit wins
        s.eq[i] = (q.eq[i] && !eq_clr[i]) || hit[i];
      end else begin
        s.eq[i] = hit[i];
      end
      s.cmp_out[i] = s.eq[i] && q.pin_en[i];
    end

    // ------------------------------
    // read data mux
    // ------------------------------
    // unmapped offsets fall through to zero data
    unique case (addr)
      hsc_pkg::OFS_CTRL:    rd = {26'h000_0000, q.pin_en, q.cmp_en, q.ring_en, q.count_en};
      hsc_pkg::OFS_RING_LO: rd = q.ring_lo;
      hsc_pkg::OFS_RING_HI: rd = q.ring_hi;
      hsc_pkg::OFS_COUNT:   rd = q.count;
      hsc_pkg::OFS_STATUS:  rd = {16'h0000, q.err, 2'b00, q.mode, q.eq, q.borrow, q.carry};
      default: begin
        for (int i = 0; i < 2; i++) begin
          ofs = 8'(hsc_pkg::OFS_CMP_BASE + 8'(i) * hsc_pkg::CMP_STRIDE);
          if (addr == ofs) begin
            rd = {28'h000_0000, q.cmp_mode[i]};
          end
          if (addr == 8'(ofs + 8'h04)) begin
            rd = q.cmp_v1[i];
          end
          if (addr == 8'(ofs + 8'h08)) begin
            rd = q.cmp_v2[i];
          end
        end
      end
    endcase
    // captured only for reads, so it stands until the next read
    if (take && !wb_req_i.we) begin
      s.rdata = rd;
    end
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  // reset forces every field, so no count or flag survives it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= hsc_pkg::ST_LINEAR;
      q.err  <= hsc_pkg::ERR_NONE;
    end else begin
      q <= s;
    end
  end

  // outputs straight from state
  // none is combinational, so outputs never glitch on a bus access
  assign wb_rsp_o.ack = q.ack;
  assign wb_rsp_o.dat = q.rdata;
  assign cmp_out_o    = q.cmp_out;
  assign carry_o      = q.carry;
  assign borrow_o     = q.borrow;

endmodule : hsc_channel

// >>> sim/hsc_channel_chk.sv
// ----
// port checker for one counter channel, bound to hsc_channel
// ----
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module hsc_channel_chk (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // watched ports
  input wire hsc_pkg::wb_req_t wb_req_i,
  input wire hsc_pkg::wb_rsp_t wb_rsp_o,
  input wire logic             count_up_i,
  input wire logic             count_dn_i,
  input wire logic [1:0]       cmp_out_o,
  input wire logic             carry_o,
  input wire logic             borrow_o
);
  logic       take_w;
  logic       cbclr_w;
  logic [3:0] quiet_reg;
  // request taken, and a carry/borrow reset write
  assign take_w  = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
  assign cbclr_w = take_w & wb_req_i.we & (wb_req_i.adr[7:2] == 6'h00) & wb_req_i.sel[0] & wb_req_i.dat[6];
  // cycles since last bus or pin activity
  always_ff @(posedge clk_i) begin
    if (rst_i || wb_req_i.cyc || count_up_i || count_dn_i) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (take_w |=> wb_rsp_o.ack)
    else $error("no ack one cycle after request");
  ack_once_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held too long");
  carry_hold_a: assert property (carry_o && !cbclr_w |=> carry_o)
    else $error("carry lost without reset control");
  borrow_hold_a: assert property (borrow_o && !cbclr_w |=> borrow_o)
    else $error("borrow lost without reset control");
  carry_cause_a: assert property ($rose(carry_o) |-> $past(count_up_i, 2) || $past(count_up_i, 3))
    else $error("carry without up step");
  borrow_cause_a: assert property ($rose(borrow_o) |-> $past(count_dn_i, 2) || $past(count_dn_i, 3))
    else $error("borrow without down step");
  cmp_settle_a: assert property (quiet_reg >= 4'h6 |-> $stable(cmp_out_o))
    else $error("compare output moved while idle");
  flag_settle_a: assert property (quiet_reg >= 4'h6 |-> $stable({carry_o, borrow_o}))
    else $error("flags moved while idle");
  cover property ($rose(carry_o));
  cover property ($rose(borrow_o));
  cover property ($rose(cmp_out_o[0]));
endmodule : hsc_channel_chk

bind hsc_channel hsc_channel_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .count_up_i(count_up_i), .count_dn_i(count_dn_i), .cmp_out_o(cmp_out_o), .carry_o(carry_o), .borrow_o(borrow_o));

// >>> sim/enc_model.sv
// ----
// encoder model: one step pulse on each request
// ----
// assumes requests only while busy_o is low
`timescale 1ns/10ps
module enc_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // step request
  input  wire logic go_i,
  input  wire logic up_i,
  input  wire logic slow_i,
  // pins and status
  output logic      pulse_up_o,
  output logic      pulse_dn_o,
  output logic      busy_o
);
  logic [3:0] ph_reg;
  logic       up_reg;
  // pin high in phases 1-2, then a low gap of 2 or 6 cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_reg <= 4'h0;
      up_reg <= 1'b0;
    end else if (ph_reg == 4'h0) begin
      ph_reg <= go_i ? 4'h1 : 4'h0;
      up_reg <= go_i ? up_i : up_reg;
    end else if (ph_reg >= (slow_i ? 4'h8 : 4'h4)) begin
      ph_reg <= 4'h0;
    end else begin
      ph_reg <= ph_reg + 4'h1;
    end
  end
  assign pulse_up_o = (ph_reg == 4'h1 || ph_reg == 4'h2) && up_reg;
  assign pulse_dn_o = (ph_reg == 4'h1 || ph_reg == 4'h2) && !up_reg;
  assign busy_o     = (ph_reg != 4'h0);
endmodule : enc_model

// >>> sim/hsc_channel_tb_top.sv
// ----
// self-checking bench for hsc_channel
// ----
// assumes enc_model drives the step pins and the bench is bus master
`timescale 1ns/10ps
module hsc_channel_tb_top;
  logic             clk_i;
  logic             rst_i;
  hsc_pkg::wb_req_t wb_req;
  hsc_pkg::wb_rsp_t wb_rsp;
  logic             go;
  logic             dir_up;
  logic             slow;
  logic             step_up;
  logic             step_dn;
  logic             busy;
  logic [1:0]       cmp_out;
  logic             carry;
  logic             borrow;
  logic [31:0]      q;
  int               err_count;
  int               total_checks;

  hsc_channel u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .count_up_i(step_up),
    .count_dn_i(step_dn), .cmp_out_o(cmp_out), .carry_o(carry), .borrow_o(borrow));
  enc_model u_enc (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .up_i(dir_up), .slow_i(slow), .pulse_up_o(step_up),
    .pulse_dn_o(step_dn), .busy_o(busy));

  always #5 clk_i = ~clk_i;

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    chk({31'h0, wb_rsp.ack}, 32'h0000_0001);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : xfer

  // encoder steps, then let the count land
  task step(input logic up, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      go <= 1'b1;
      dir_up <= up;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy === 1'b1) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : step

  task count_is(input logic [31:0] e);
    xfer(1'b0, 8'h24, 32'h0000_0000);
    chk(q, e);
  endtask : count_is

  task status_is(input logic [7:0] err, input logic [1:0] st);
    xfer(1'b0, 8'h28, 32'h0000_0000);
    chk({24'h0, q[15:8]}, {24'h0, err});
    chk({30'h0, q[5:4]}, {30'h0, st});
  endtask : status_is

  // stop counting, clear flags, drop ring, preset, then start
  task setup(input logic [31:0] c, input logic [31:0] ctrl);
    xfer(1'b1, 8'h00, 32'h0000_0040);
    xfer(1'b1, 8'h24, c);
    xfer(1'b1, 8'h00, ctrl);
  endtask : setup

  function automatic logic hit(input logic [3:0] m, input logic signed [31:0] c);
    case (m)
      4'h0: hit = c < 10;
      4'h1: hit = c <= 10;
      4'h2: hit = c == 10;
      4'h3: hit = c >= 10;
      4'h4: hit = c > 10;
      4'h5: hit = c >= 10 && c <= 20;
      default: hit = c <= 10 || c >= 20;
    endcase
  endfunction : hit

  task t_reset;
    for (int a = 0; a <= 40; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0000_0000);
      chk(q, 32'h0000_0000);
    end
    $display("reset values done");
  endtask : t_reset

  task t_linear;
    setup(32'h7FFF_FFFE, 32'h0000_0001);
    step(1'b1, 2);
    count_is(32'h7FFF_FFFF);
    chk({31'h0, carry}, 32'h0000_0001);
    step(1'b0, 1);
    count_is(32'h7FFF_FFFE);
    xfer(1'b1, 8'h00, 32'h0000_0041);
    chk({31'h0, carry}, 32'h0000_0000);
    $display("linear limit done");
  endtask : t_linear

  task t_ring;
    xfer(1'b1, 8'h04, 32'h0000_000A);
    xfer(1'b1, 8'h08, 32'h0000_0014);
    setup(32'h0000_0012, 32'h0000_0003);
    step(1'b1, 2);
    count_is(32'h0000_000A);
    chk({31'h0, carry}, 32'h0000_0001);
    status_is(8'h00, 2'h1);
    setup(32'h0000_000B, 32'h0000_0003);
    slow <= 1'b1;
    step(1'b0, 2);
    count_is(32'h0000_0014);
    chk({31'h0, borrow}, 32'h0000_0001);
    step(1'b0, 1);
    count_is(32'h0000_0013);
    slow <= 1'b0;
    $display("ring wrap done");
  endtask : t_ring

  task t_outside;
    setup(32'h0000_0005, 32'h0000_0003);
    status_is(8'h1B, 2'h2);
    step(1'b1, 5);
    count_is(32'h0000_000A);
    status_is(8'h1B, 2'h1);
    setup(32'h7FFF_FFFE, 32'h0000_0003);
    status_is(8'h1B, 2'h3);
    step(1'b1, 2);
    count_is(32'h7FFF_FFFF);
    xfer(1'b1, 8'h24, 32'h8000_0001);
    step(1'b0, 2);
    count_is(32'h8000_0000);
    chk({31'h0, borrow}, 32'h0000_0001);
    status_is(8'h1B, 2'h3);
    $display("ring out of range done");
  endtask : t_outside

  task t_compare;
    logic e;
    logic f;
    for (int a = 0; a < 2; a++) begin
      xfer(1'b1, 8'(16 + a * 12), 32'h0000_000A);
      xfer(1'b1, 8'(20 + a * 12), 32'h0000_0014);
    end
    for (int m = 0; m < 7; m++) begin
      for (int k = 1; k < 6; k++) begin
        xfer(1'b1, 8'h00, 32'h0000_0000);
        xfer(1'b1, 8'h0C, 32'(m));
        xfer(1'b1, 8'h18, 32'(6 - m));
        xfer(1'b1, 8'h24, 32'(5 * k));
        xfer(1'b1, 8'h00, 32'h0000_001C);
        e = hit(4'(m), 32'(5 * k));
        f = hit(4'(6 - m), 32'(5 * k));
        xfer(1'b0, 8'h28, 32'h0000_0000);
        chk({30'h0, q[3:2]}, {30'h0, f, e});
        chk({30'h0, cmp_out}, {31'h0, e});
      end
    end
    xfer(1'b1, 8'h00, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    chk({30'h0, cmp_out}, 32'h0000_0000);
    xfer(1'b1, 8'h0C, 32'h0000_0007);
    status_is(8'h17, 2'h0);
    xfer(1'b1, 8'h0C, 32'h0000_0002);
    xfer(1'b1, 8'h28, 32'h0000_0000);
    status_is(8'h00, 2'h0);
    $display("compare modes done");
  endtask : t_compare

  task t_equal;
    setup(32'h0000_0009, 32'h0000_0015);
    step(1'b1, 2);
    chk({30'h0, cmp_out}, 32'h0000_0001);
    xfer(1'b1, 8'h00, 32'h0000_0095);
    repeat (2) @(posedge clk_i);
    chk({30'h0, cmp_out}, 32'h0000_0000);
    $display("equality latch done");
  endtask : t_equal

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_req = '0;
    go = 1'b0;
    dir_up = 1'b0;
    slow = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_linear;
    t_ring;
    t_outside;
    t_compare;
    t_equal;
    complete_run;
  end

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("mismatch at %0t: watchdog expired", $time);
    err_count++;
    complete_run;
  end
endmodule : hsc_channel_tb_top
